// ---- logic/pcc_defs.vh ----
// Purpose: Constants for the printer channel controller
// Assumes: 100 MHz mclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCC_OFS_CMD      8'h00
`define PCC_OFS_STATUS   8'h04
`define PCC_OFS_DATA     8'h08
`define PCC_OFS_VECTOR   8'h0C
`define PCC_OFS_ISR      8'h10
`define PCC_OFS_IMR      8'h14
`define PCC_OFS_COUNT    8'h18
`define PCC_OFS_SEQ      8'h1C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PCC_CMD_BEGIN    0
`define PCC_CMD_RESET    1
`define PCC_CMD_ADDR_LSB 4
`define PCC_ST_BUSY      0
`define PCC_ST_POWER     1
`define PCC_ST_ACK       2
`define PCC_ST_READY     3
`define PCC_ST_PAPER     4
`define PCC_ST_CONN      5
`define PCC_IRQ_DS       0
`define PCC_IRQ_END      1
`define PCC_IMR_RESET    2'h0
`define PCC_CNT_RESET    16'h0000
`define PCC_DEV_ADDR     8'hFE
`define PCC_CHANNEL      3'h7
`define PCC_END_OFS      3'h4
`define PCC_AXI_OKAY     2'h0
`define PCC_AXI_SLVERR   2'h2

// ----------------------------------------------------------------
// Sequence addresses and timing
// ----------------------------------------------------------------
`define PCC_SEQ_IDLE     4'h0
`define PCC_SEQ_START1   4'h1
`define PCC_SEQ_START2   4'h2
`define PCC_SEQ_DATA     4'h3
`define PCC_SEQ_DSREQ    4'h4
`define PCC_SEQ_WAITACK  4'h6
`define PCC_SEQ_STROBE   4'hD
`define PCC_SEQ_END      4'hF
`define PCC_CLK_NS       10
`define PCC_STROBE_NS    500
`define PCC_STROBE_CYC   ((`PCC_STROBE_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)

`endif

// ---- logic/pcc_printer_ctrl.v ----
// Purpose: Printer channel controller behind an AXI4-Lite register port
// Assumes: Printer pins are asynchronous and pass two flip-flops
// Notes:   Summary of operation below
//
// Summary of operation
// R1: Default strap 2'b11 puts the 64 vectors at C0 through FF.
// R2: Other straps move the block; channel offsets inside it stay the same.
// R3: A status request returns at most eight bits, in positions 0 to 7.
// R4: A read of the status word is the input with function LSB one.
// R5: Wider status needs several requests; here one byte always suffices.
// R6: Data service requests are raised even with interrupts masked.
// R7: While a data service request is pending the sequencer stalls.
// R8: A branch command during a pending request only acknowledges it.
// R9: After start, printer status is checked before the first data request.
// R10: Block end interrupt after the last byte or on any error.
// R11: Channel 7, device address FE, vectors F8 and FC by default.
// R12: Status sits on bits 0 to 5, all other bits read zero.
// R13: Host keeps a byte transfer instruction in the data service vector.
// R14: Without interrupts the host polls status for the ready bit.
// R15: Each byte gets a 500 ns low strobe, then waits for acknowledge.
// R16: Power checked before each byte and while waiting acknowledge false.
// R17: Entry 1 checks paper low, entry 2 checks cable connection.
// R18: A data service request also raises the ready flag, status bit 3.
// R19: After an error no strobe is issued until a new start.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pcc_defs.vh"

module pcc_printer_ctrl (
    // Clock, reset, enable
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        ce,
    // Vector block strap
    input  wire [1:0]  vec_strap,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Channel distributor side
    output reg         ds_req,
    output reg         host_ready_flag,
    output reg         block_end_interrupt,
    output reg  [7:0]  ds_vector,
    output reg  [7:0]  end_vector,
    output reg         irq,
    // Printer pins
    output reg  [7:0]  prn_data,
    output reg         prn_strobe_n,
    input  wire        prn_busy,
    input  wire        prn_power,
    input  wire        prn_ack_n,
    input  wire        prn_paper_low,
    input  wire        prn_connected_n
);

    localparam [3:0] S_IDLE    = `PCC_SEQ_IDLE;
    localparam [3:0] S_START1  = `PCC_SEQ_START1;
    localparam [3:0] S_START2  = `PCC_SEQ_START2;
    localparam [3:0] S_DATA    = `PCC_SEQ_DATA;
    localparam [3:0] S_DSREQ   = `PCC_SEQ_DSREQ;
    localparam [3:0] S_STROBE  = `PCC_SEQ_STROBE;
    localparam [3:0] S_WAITACK = `PCC_SEQ_WAITACK;
    localparam [3:0] S_END     = `PCC_SEQ_END;
    localparam [31:0] STROBE_LAST = `PCC_STROBE_CYC - 1;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [6:0]  sync1_reg;
    reg  [6:0]  sync2_reg;
    reg  [7:0]  awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [5:0]  strobe_cnt_reg;
    reg  [15:0] count_reg;
    reg         err_reg;
    reg  [1:0]  isr_reg;
    reg  [1:0]  isr_next;
    reg  [1:0]  imr_reg;
    reg         ev_ds;
    reg         ev_end;
    reg         err_set;
    reg         byte_done;
    reg  [31:0] rd_word;
    reg         rd_hit;
    wire        busy_t;
    wire        power_t;
    wire        ack_t;
    wire        paper_t;
    wire        conn_t;
    wire [1:0]  strap_s;
    wire [5:0]  status_word;
    wire        wr_go;
    wire        wr_hit;
    wire        cmd_wr;
    wire        data_wr;
    wire        cmd_rst;
    wire        cmd_begin;
    wire [3:0]  cmd_addr;
    wire        ds_ack;
    wire [7:0]  ds_vec_w;

    // Printer lines as true/false states, whatever their pin level
    assign busy_t  = sync2_reg[0];
    assign power_t = sync2_reg[1];
    assign ack_t   = ~sync2_reg[2];
    assign paper_t = sync2_reg[3];
    assign conn_t  = ~sync2_reg[4];
    assign strap_s = sync2_reg[6:5];

    // Six status bits; upper bits are padded with zero on read
    assign status_word = {conn_t, paper_t, host_ready_flag, ack_t, power_t, busy_t}; // R12

    // Write decode: both AXI channels held, no response outstanding
    assign wr_go     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign cmd_wr    = wr_go & (awaddr_reg == `PCC_OFS_CMD) & wstrb_reg[0];
    assign data_wr   = wr_go & (awaddr_reg == `PCC_OFS_DATA) & wstrb_reg[0];
    assign cmd_rst   = wdata_reg[`PCC_CMD_RESET];
    assign cmd_begin = wdata_reg[`PCC_CMD_BEGIN];
    assign cmd_addr  = wdata_reg[`PCC_CMD_ADDR_LSB+3:`PCC_CMD_ADDR_LSB];
    assign wr_hit    = (awaddr_reg[7:5] == 3'h0) & (awaddr_reg[1:0] == 2'h0);

    // Pending request is acknowledged by a byte or any branch command
    assign ds_ack = (state_reg == S_DSREQ) & (data_wr | (cmd_wr & ~cmd_rst)); // R8

    // Vector block base from strap, channel slot of eight words
    assign ds_vec_w = {strap_s, `PCC_CHANNEL, 3'h0}; // R1 R2 R11

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 7'h04; // Ack idles high
            sync2_reg <= 7'h04;
        end else if (ce) begin
            sync1_reg <= {vec_strap, prn_connected_n, prn_paper_low, prn_ack_n, prn_power, prn_busy};
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        ev_ds      = 1'b0;
        ev_end     = 1'b0;
        err_set    = 1'b0;
        byte_done  = 1'b0;
        case (state_reg)
            S_IDLE: begin
                state_next = S_IDLE;
            end
            S_START1: begin
                if (paper_t) begin // R17
                    err_set    = 1'b1;
                    state_next = S_END;
                end else begin
                    state_next = S_START2;
                end
            end
            S_START2: begin
                if (!conn_t) begin // R17
                    err_set    = 1'b1;
                    state_next = S_END;
                end else if (count_reg == 16'h0000) begin
                    state_next = S_END;
                end else begin
                    state_next = S_DATA; // R9
                end
            end
            S_DATA: begin
                // Power is rechecked every cycle acknowledge is still true
                if (!power_t) begin // R16
                    err_set    = 1'b1;
                    state_next = S_END;
                end else if (!ack_t) begin
                    ev_ds      = 1'b1; // R6
                    state_next = S_DSREQ;
                end
            end
            S_DSREQ: begin
                if (ds_ack) begin // R7
                    state_next = S_STROBE;
                end
            end
            S_STROBE: begin
                if (strobe_cnt_reg == STROBE_LAST[5:0]) begin // R15
                    state_next = S_WAITACK;
                end
            end
            S_WAITACK: begin
                if (ack_t) begin // R15
                    byte_done  = 1'b1;
                    state_next = (count_reg == 16'h0001) ? S_END : S_DATA;
                end
            end
            S_END: begin
                ev_end     = 1'b1; // R10
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        // Reset command preempts the next state, ev_ds and ev_end, and cancels requests
        if (cmd_wr && cmd_rst) begin
            state_next = S_IDLE;
            ev_ds      = 1'b0;
            ev_end     = 1'b0;
        end else if (cmd_wr && cmd_begin && state_reg == S_IDLE) begin
            if (cmd_addr == S_START1 || cmd_addr == S_START2) begin // R17
                state_next = cmd_addr;
            end
        end
    end

    // Sticky events; a new event wins over a one written to clear it
    always @* begin
        isr_next = isr_reg;
        if (wr_go && awaddr_reg == `PCC_OFS_ISR && wstrb_reg[0]) begin
            isr_next = isr_next & ~wdata_reg[1:0];
        end
        isr_next = isr_next | {ev_end, ev_ds};
    end

    // ----------------------------------------------------------------
    // Sequencer, printer and interrupt registers
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg           <= S_IDLE;
            strobe_cnt_reg      <= 6'h00;
            count_reg           <= `PCC_CNT_RESET;
            err_reg             <= 1'b0;
            isr_reg             <= 2'h0;
            imr_reg             <= `PCC_IMR_RESET;
            irq                 <= 1'b0;
            ds_req              <= 1'b0;
            host_ready_flag     <= 1'b0;
            block_end_interrupt <= 1'b0;
            ds_vector           <= 8'h00;
            end_vector          <= 8'h00;
            prn_data            <= 8'h00;
            prn_strobe_n        <= 1'b1;
        end else if (ce) begin
            state_reg           <= state_next;
            isr_reg             <= isr_next;
            irq                 <= |(isr_next & imr_reg);
            ds_req              <= (state_next == S_DSREQ);
            host_ready_flag     <= (state_next == S_DSREQ); // R18
            block_end_interrupt <= ev_end; // R10
            ds_vector           <= ds_vec_w; // R11
            end_vector          <= {ds_vec_w[7:3], `PCC_END_OFS};
            // Error lock holds strobe off until the next start
            prn_strobe_n        <= ~((state_next == S_STROBE) & ~err_reg); // R19
            strobe_cnt_reg      <= (state_reg == S_STROBE) ? strobe_cnt_reg + 6'h01 : 6'h00;
            if (err_set) begin
                err_reg <= 1'b1; // R19
            end else if (state_reg == S_IDLE && (state_next == S_START1 || state_next == S_START2)) begin
                err_reg <= 1'b0;
            end
            if (data_wr) begin
                prn_data <= wdata_reg[7:0];
            end
            if (wr_go && awaddr_reg == `PCC_OFS_IMR && wstrb_reg[0]) begin
                imr_reg <= wdata_reg[1:0];
            end
            // Software write loads the byte count; each acknowledged byte takes one off
            if (wr_go && awaddr_reg == `PCC_OFS_COUNT) begin
                if (wstrb_reg[0]) count_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) count_reg[15:8] <= wdata_reg[15:8];
            end else if (byte_done) begin
                count_reg <= count_reg - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PCC_AXI_OKAY;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `PCC_AXI_OKAY : `PCC_AXI_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    // Status read is the status request; one byte covers every bit here
    always @* begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `PCC_OFS_CMD:    rd_word = 32'h0000_0000;
            `PCC_OFS_STATUS: rd_word = {26'h0, status_word}; // R3 R4 R5 R12
            `PCC_OFS_DATA:   rd_word = {24'h0, prn_data};
            `PCC_OFS_VECTOR: rd_word = {8'h00, `PCC_DEV_ADDR, end_vector, ds_vector}; // R11
            `PCC_OFS_ISR:    rd_word = {30'h0, isr_reg};
            `PCC_OFS_IMR:    rd_word = {30'h0, imr_reg};
            `PCC_OFS_COUNT:  rd_word = {16'h0, count_reg};
            `PCC_OFS_SEQ:    rd_word = {27'h0, err_reg, state_reg};
            default:         rd_hit  = 1'b0;
        endcase
    end

    // Data is sampled at acceptance so the reply reflects that edge
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PCC_AXI_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? `PCC_AXI_OKAY : `PCC_AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // pcc_printer_ctrl

// ---- test/pcc_printer_ctrl_asserts.sv ----
// Purpose: Port checks on the printer channel controller
// Assumes: One mclk domain, rst_b low resets
// Notes:   Bound into every controller instance
`timescale 1ns/1ps
`include "pcc_defs.vh"

module pcc_chk (
    // Clock and reset
    input wire        mclk,
    input wire        rst_b,
    // Register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    // Distributor and printer side
    input wire        ds_req,
    input wire        host_ready_flag,
    input wire        block_end_interrupt,
    input wire [7:0]  ds_vector,
    input wire [7:0]  end_vector,
    input wire        prn_strobe_n,
    input wire        prn_ack_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // -----
    // Helpers
    // -----
    // Strobe low length; a status read in flight
    reg [6:0] low_cnt;
    reg       stat_rd;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 7'h00;
            stat_rd <= 1'b0;
        end else begin
            low_cnt <= prn_strobe_n ? 7'h00 : low_cnt + 7'h01;
            if (s_axi_arvalid && s_axi_arready)
                stat_rd <= (s_axi_araddr == `PCC_OFS_STATUS);
        end
    end
    // -----
    // Properties
    // -----
    // Strobe ended while the printer has not answered yet
    sequence strobe_end_s;
        $rose(prn_strobe_n) ##0 prn_ack_n [*3];
    endsequence
    sequence wr_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Guard on a nonzero count skips a strobe cut by reset
    strobe_width_a: assert property ($rose(prn_strobe_n) && low_cnt != 7'h00 |-> low_cnt == 7'h32)
        else $error("strobe low time wrong");
    ack_wait_a: assert property (strobe_end_s |-> !ds_req)
        else $error("request before acknowledge");
    ready_mirror_a: assert property (host_ready_flag == ds_req)
        else $error("ready flag differs from request");
    stall_hold_a: assert property (ds_req |-> prn_strobe_n)
        else $error("strobe while request pending");
    strobe_cause_a: assert property ($fell(prn_strobe_n) |-> $past(ds_req))
        else $error("strobe without served request");
    end_pulse_a: assert property (block_end_interrupt |=> !block_end_interrupt)
        else $error("block end not a pulse");
    vec_layout_a: assert property (ds_vector != 8'h00 |-> ds_vector[5:0] == 6'h38 && end_vector == ds_vector + 8'h04)
        else $error("vector layout wrong");
    stat_zero_a: assert property (s_axi_rvalid && stat_rd |-> s_axi_rdata[31:6] == 26'h0)
        else $error("status upper bits not zero");
    wr_resp_a: assert property (wr_take_s |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule // pcc_chk

bind pcc_printer_ctrl pcc_chk u_chk (.*);

// ---- test/pcc_prn_model.sv ----
// Purpose: Behavioural parallel printer for the bench
// Assumes: Data is latched on the rising strobe edge
// Notes:   Acknowledge ack_dly+1 cycles after the latch, low for four
`timescale 1ns/1ps

module pcc_prn_model (
    // Clock
    input  wire        mclk,
    // Printer pins
    input  wire  [7:0] prn_data,
    input  wire        prn_strobe_n,
    output wire        prn_ack_n,
    output wire        prn_busy,
    // Bench control and view
    input  wire  [7:0] ack_dly,
    output logic [7:0] last_byte,
    output logic [7:0] byte_cnt
);
    logic [8:0] tmr = 9'h000;
    logic       stb_q = 1'b1;
    initial byte_cnt = 8'h00;
    // Released acknowledge returns high through its pull-up
    assign prn_busy  = (tmr > 9'h004);
    assign prn_ack_n = !(tmr != 9'h000 && tmr < 9'h005);
    // Rising strobe latches the byte and starts the reply
    always @(posedge mclk) begin
        stb_q <= prn_strobe_n;
        if (prn_strobe_n && !stb_q) begin
            last_byte <= prn_data;
            byte_cnt  <= byte_cnt + 8'h01;
            tmr       <= {1'b0, ack_dly} + 9'h005;
        end else if (tmr != 9'h000)
            tmr <= tmr - 9'h001;
    end
endmodule // pcc_prn_model

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the printer channel controller
// Assumes: ce and wstrb tied on, printer model on the pins
// Notes:   All waits are bounded; hangs end in close_out
`timescale 1ns/1ps
`include "pcc_defs.vh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t %s", $time, m); end end

module tb_top;
    // {paper_low, connected_n, power, entry 1} per fault case
    localparam logic [15:0] FAULT_TBL = 16'hA06B;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic [1:0]  vec_strap = 2'b11;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        prn_power = 1'b1, prn_paper_low = 1'b0, prn_connected_n = 1'b0;
    logic [7:0]  ack_dly = 8'h03;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         ds_req, host_ready_flag, block_end_interrupt, irq, prn_strobe_n, prn_ack_n, prn_busy;
    wire [7:0]   ds_vector, end_vector, prn_data, last_byte, byte_cnt;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic        ok;
    logic [7:0]  n0;

    pcc_printer_ctrl uut (.*);
    pcc_prn_model    prn (.*);

    initial begin
        forever #5 mclk = ~mclk;
    end
    // Run needs a few hundred cycles; ceiling leaves wide margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // -----
    // Bus tasks
    // -----
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, pb;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b0;
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (pa || pw || !pb) begin
            @(posedge mclk);
            if (pa && s_axi_awready) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                pb = 1'b1;
                rsp = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        logic pa, pr;
        pa = 1'b1;
        pr = 1'b0;
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (pa || !pr) begin
            @(posedge mclk);
            if (pa && s_axi_arready) begin
                pa = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                pr = 1'b1;
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
    // Wait for request (0), block end (1) or byte count n0 (2)
    task automatic wait_sig(input int which);
        ok = 1'b0;
        repeat (600) begin
            @(negedge mclk);
            if ((which == 0 ? ds_req : which == 1 ? block_end_interrupt : byte_cnt == n0) === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
    endtask
    // -----
    // Scenarios
    // -----
    task automatic t_regs;
        axr(`PCC_OFS_IMR);
        `CHK(rd[1:0], `PCC_IMR_RESET, "mask reset value")
        axr(`PCC_OFS_COUNT);
        `CHK(rd[15:0], `PCC_CNT_RESET, "count reset value")
        axr(`PCC_OFS_VECTOR);
        `CHK(rd, 32'h00FEFCF8, "default vectors")
        axr(`PCC_OFS_STATUS);
        `CHK(rd, 32'h00000022, "idle status word")
        axr(8'h20);
        `CHK({rsp, rd}, {`PCC_AXI_SLVERR, 32'h0}, "unmapped read")
        axw(8'h24, 32'hFFFFFFFF);
        `CHK(rsp, `PCC_AXI_SLVERR, "unmapped write")
    endtask
    // Every strap moves the block, offsets stay
    task automatic t_strap;
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            vec_strap <= s[1:0];
            repeat (4) @(posedge mclk);
            axr(`PCC_OFS_VECTOR);
            `CHK(rd[15:0], {s[1:0], 6'h3C, s[1:0], 6'h38}, "strapped vectors")
        end
    endtask
    // Two bytes with interrupts on
    task automatic t_print;
        axw(`PCC_OFS_IMR, 32'h3);
        axw(`PCC_OFS_COUNT, 32'h2);
        n0 = byte_cnt;
        axw(`PCC_OFS_CMD, 32'h11);
        for (int i = 0; i < 2; i++) begin
            wait_sig(0);
            `CHK({ok, host_ready_flag}, 2'b11, "data request")
            axr(`PCC_OFS_STATUS);
            `CHK({rd[`PCC_ST_READY], irq}, 2'b11, "ready bit and irq")
            axw(`PCC_OFS_DATA, 32'hA5 + i);
            n0++;
            wait_sig(2);
            `CHK({ok, last_byte}, {1'b1, 8'hA5 + i[7:0]}, "byte latched")
        end
        wait_sig(1);
        `CHK(ok, 1'b1, "block end after last byte")
        axr(`PCC_OFS_ISR);
        `CHK(rd[1:0], 2'b11, "both events latched")
        axw(`PCC_OFS_ISR, 32'h3);
        repeat (2) @(negedge mclk);
        `CHK(irq, 1'b0, "irq after clear")
    endtask
    // Masked request, stall, branch as acknowledge, slow printer
    task automatic t_branch;
        axw(`PCC_OFS_IMR, 32'h0);
        axw(`PCC_OFS_COUNT, 32'h1);
        ack_dly <= 8'h3C;
        n0 = byte_cnt;
        axw(`PCC_OFS_CMD, 32'h21);
        wait_sig(0);
        `CHK(ok, 1'b1, "request while masked")
        repeat (20) @(negedge mclk);
        `CHK({ds_req, irq, byte_cnt}, {2'b10, n0}, "stalled without irq")
        axw(`PCC_OFS_CMD, 32'hE0);
        n0++;
        wait_sig(2);
        `CHK(ok, 1'b1, "branch acknowledged")
        wait_sig(1);
        `CHK(ok, 1'b1, "block end after one byte")
        axw(`PCC_OFS_ISR, 32'h3);
    endtask
    // Fault entries end the block; entry 2 skips paper low
    task automatic t_faults;
        logic [3:0] cs;
        axw(`PCC_OFS_COUNT, 32'h1);
        for (int k = 0; k < 4; k++) begin
            cs = FAULT_TBL[4*k +: 4];
            @(posedge mclk);
            prn_paper_low   <= cs[3];
            prn_connected_n <= cs[2];
            prn_power       <= cs[1];
            repeat (4) @(posedge mclk);
            n0 = byte_cnt;
            axw(`PCC_OFS_CMD, cs[0] ? 32'h11 : 32'h21);
            wait_sig(k == 3 ? 0 : 1);
            `CHK({ok, byte_cnt}, {1'b1, n0}, "fault entry outcome")
            axr(`PCC_OFS_SEQ);
            `CHK(rd[4:0], k == 3 ? 5'h04 : 5'h10, "sequencer state")
        end
        axw(`PCC_OFS_CMD, 32'h2);
        @(negedge mclk);
        `CHK({ds_req, prn_strobe_n}, 2'b01, "reset cancels request")
    endtask
    task automatic close_out;
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_strap();
        t_print();
        t_branch();
        t_faults();
        close_out();
    end
endmodule // tb_top
